// File: include/adia_consts.svh
// constants of the analog die interrupt aggregator
//
// Functional notes
// - Upper pending-flag bits 7..3 show timer wrap and timer channel 3..0 requests, 1 while pending.
// - Upper pending-flag bit 2 shows the LIN driver overheat request, 1 while present.
// - Upper pending-flag bit 1 shows the high die temperature request, 1 while pending.
// - Upper pending-flag bit 0 shows an undervoltage request or a wake from cranking mode.
// - Lower pending-flag bits 7..6 read 0, bit 5 is the trim request, bit 4 the lifetime wrap.
// - Lower pending-flag bit 3 shows a pending measurement completion request.
// - Lower pending-flag bits 2..0 show serial receive, transmit and fault requests.
// - The vector register gives the code of the highest priority unmasked pending source, bits 7..5 zero.
// - The vector reads 0x00 when nothing is pending, which also stands for a stop mode wake.
// - Codes run 0x01 undervoltage (highest) through 0x0e trim request (lowest) in fixed order.
// - Upper mask bits 7..3 mask timer wrap and timer channels 3..0; 0 enables, 1 disables.
// - Upper mask bits 2..0 mask LIN overheat, die hot and undervoltage; 0 enables, 1 disables.
// - Offsets decode relative to base 0x0200 for blocking and 0x300 for non-blocking access.
// - Lower mask bits 5..0 mask trim, lifetime, measurement and serial rx, tx, fault sources.
// - The masks act as a global enable for every source; per-source enables stay at the source.
`ifndef ADIA_CONSTS_SVH
`define ADIA_CONSTS_SVH

// ****************************************
// address map
// ****************************************
`define ADIA_BASE_BLOCKING 16'h0200
`define ADIA_BASE_POSTED 16'h0300
`define ADIA_WIN_LSB 5
`define ADIA_OFF_PEND_HI 5'h08
`define ADIA_OFF_PEND_LO 5'h09
`define ADIA_OFF_VECTOR 5'h0a
`define ADIA_OFF_RSVD 5'h0b
`define ADIA_OFF_MASK_HI 5'h0c
`define ADIA_OFF_MASK_LO 5'h0d
`define ADIA_OFF_EVT_STS_HI 5'h10
`define ADIA_OFF_EVT_STS_LO 5'h11
`define ADIA_OFF_EVT_CLR_HI 5'h12
`define ADIA_OFF_EVT_CLR_LO 5'h13
`define ADIA_OFF_EVT_EN_HI 5'h14
`define ADIA_OFF_EVT_EN_LO 5'h15

// ****************************************
// fields and reset values
// ****************************************
`define ADIA_NUM_SRC 14
`define ADIA_LO_FIELD_W 6
`define ADIA_MASK_RESET 14'h3fff
`define ADIA_EVT_EN_RESET 14'h0000
`define ADIA_VEC_NONE 5'h00

`endif

// File: include/adia_pkg.sv
// types of the analog die interrupt aggregator
package adia_pkg;
   typedef logic [4:0] adia_vec_type;
   typedef logic [13:0] adia_src_type;
   typedef enum logic [3:0] {
      ADIA_SEL_NONE,
      ADIA_SEL_PEND_HI,
      ADIA_SEL_PEND_LO,
      ADIA_SEL_VECTOR,
      ADIA_SEL_RSVD,
      ADIA_SEL_MASK_HI,
      ADIA_SEL_MASK_LO,
      ADIA_SEL_STS_HI,
      ADIA_SEL_STS_LO,
      ADIA_SEL_CLR_HI,
      ADIA_SEL_CLR_LO,
      ADIA_SEL_EN_HI,
      ADIA_SEL_EN_LO
   } adia_sel_type;
endpackage : adia_pkg

// File: logic/adia_aggregator.sv
// analog die interrupt aggregator: pending flags, priority vector, masks
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`include "adia_consts.svh"

module adia_aggregator (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // register port
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // source requests
   input wire logic undervoltage_pending_i,
   input wire logic die_hot_pending_i,
   input wire logic lin_driver_overheat_pending_i,
   input wire logic timer_chan0_pending_i,
   input wire logic timer_chan1_pending_i,
   input wire logic timer_chan2_pending_i,
   input wire logic timer_chan3_pending_i,
   input wire logic timer_wrap_pending_i,
   input wire logic sci_fault_pending_i,
   input wire logic sci_transmit_pending_i,
   input wire logic sci_receive_pending_i,
   input wire logic measure_done_pending_i,
   input wire logic lifetime_wrap_pending_i,
   input wire logic trim_request_pending_i,
   // interrupt outputs
   output logic irq_req_o,
   output logic irq_o
);
   import adia_pkg::*;

   // ****************************************
   // reset release
   // ****************************************
   logic rst_sync1_q;
   logic rst_n_q;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_sync1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_sync1_q <= 1'b1;
         rst_n_q <= rst_sync1_q;
      end
   end

   // ****************************************
   // helpers
   // ****************************************
   // both bases map the same registers; the posted alias differs only on the bus side
   function automatic adia_sel_type decode_sel(input logic [15:0] addr);
      logic [4:0] off;
      logic hit;
      off = addr[`ADIA_WIN_LSB-1:0];
      hit = (addr[15:`ADIA_WIN_LSB] == 11'(`ADIA_BASE_BLOCKING >> `ADIA_WIN_LSB)) ||
            (addr[15:`ADIA_WIN_LSB] == 11'(`ADIA_BASE_POSTED >> `ADIA_WIN_LSB));
      decode_sel = ADIA_SEL_NONE;
      if (hit) begin
         unique case (off)
            `ADIA_OFF_PEND_HI: decode_sel = ADIA_SEL_PEND_HI;
            `ADIA_OFF_PEND_LO: decode_sel = ADIA_SEL_PEND_LO;
            `ADIA_OFF_VECTOR: decode_sel = ADIA_SEL_VECTOR;
            `ADIA_OFF_RSVD: decode_sel = ADIA_SEL_RSVD;
            `ADIA_OFF_MASK_HI: decode_sel = ADIA_SEL_MASK_HI;
            `ADIA_OFF_MASK_LO: decode_sel = ADIA_SEL_MASK_LO;
            `ADIA_OFF_EVT_STS_HI: decode_sel = ADIA_SEL_STS_HI;
            `ADIA_OFF_EVT_STS_LO: decode_sel = ADIA_SEL_STS_LO;
            `ADIA_OFF_EVT_CLR_HI: decode_sel = ADIA_SEL_CLR_HI;
            `ADIA_OFF_EVT_CLR_LO: decode_sel = ADIA_SEL_CLR_LO;
            `ADIA_OFF_EVT_EN_HI: decode_sel = ADIA_SEL_EN_HI;
            `ADIA_OFF_EVT_EN_LO: decode_sel = ADIA_SEL_EN_LO;
            default: decode_sel = ADIA_SEL_NONE;
         endcase
      end
   endfunction : decode_sel

   // bit i holds the source with code i+1, so the lowest set bit wins
   function automatic adia_vec_type pick_vector(input adia_src_type act);
      pick_vector = `ADIA_VEC_NONE;
      for (int i = `ADIA_NUM_SRC - 1; i >= 0; i--) begin
         if (act[i]) begin
            pick_vector = 5'(i + 1);
         end
      end
   endfunction : pick_vector

   // ****************************************
   // source capture
   // ****************************************
   adia_src_type src_d;
   adia_src_type req_q;
   adia_src_type mask_q;
   adia_src_type active;
   adia_src_type active_prev_q;
   adia_src_type rise;
   adia_vec_type vector;
   adia_sel_type wr_sel;
   adia_sel_type rd_sel;

   // order matches the priority codes and the flag bit layout
   assign src_d = {trim_request_pending_i,
                   lifetime_wrap_pending_i,
                   measure_done_pending_i,
                   sci_receive_pending_i,
                   sci_transmit_pending_i,
                   sci_fault_pending_i,
                   timer_wrap_pending_i,
                   timer_chan3_pending_i,
                   timer_chan2_pending_i,
                   timer_chan1_pending_i,
                   timer_chan0_pending_i,
                   lin_driver_overheat_pending_i,
                   die_hot_pending_i,
                   undervoltage_pending_i};

   // flags follow the request lines; clearing is done at each source
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         req_q <= '0;
      end else begin
         req_q <= src_d;
      end
   end

   assign active = req_q & ~mask_q;
   assign vector = pick_vector(active);
   assign wr_sel = wr_i ? decode_sel(addr_i) : ADIA_SEL_NONE;
   assign rd_sel = rd_i ? decode_sel(addr_i) : ADIA_SEL_NONE;

   // ****************************************
   // global masks
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mask_q <= `ADIA_MASK_RESET;
      end else begin
         if (wr_sel == ADIA_SEL_MASK_HI) begin
            mask_q[7:0] <= wdata_i;
         end
         if (wr_sel == ADIA_SEL_MASK_LO) begin
            mask_q[13:8] <= wdata_i[`ADIA_LO_FIELD_W-1:0];
         end
      end
   end

   // ****************************************
   // event status and interrupt
   // ****************************************
   adia_src_type evt_sts_q;
   adia_src_type evt_en_q;
   adia_src_type evt_clr;

   assign rise = active & ~active_prev_q;
   always_comb begin
      evt_clr = '0;
      if (wr_sel == ADIA_SEL_CLR_HI) begin
         evt_clr[7:0] = wdata_i;
      end
      if (wr_sel == ADIA_SEL_CLR_LO) begin
         evt_clr[13:8] = wdata_i[`ADIA_LO_FIELD_W-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         active_prev_q <= '0;
      end else begin
         active_prev_q <= active;
      end
   end

   // a new edge in the clearing cycle survives the clear
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         evt_sts_q <= '0;
      end else begin
         evt_sts_q <= (evt_sts_q & ~evt_clr) | rise;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         evt_en_q <= `ADIA_EVT_EN_RESET;
      end else begin
         if (wr_sel == ADIA_SEL_EN_HI) begin
            evt_en_q[7:0] <= wdata_i;
         end
         if (wr_sel == ADIA_SEL_EN_LO) begin
            evt_en_q[13:8] <= wdata_i[`ADIA_LO_FIELD_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         irq_o <= 1'b0;
         irq_req_o <= 1'b0;
      end else begin
         irq_o <= |(evt_sts_q & evt_en_q);
         irq_req_o <= |active;
      end
   end

   // ****************************************
   // read data
   // ****************************************
   // rdata only carries meaning in the cycle after a read; it drops to zero otherwise
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata_o <= '0;
      end else begin
         unique case (rd_sel)
            ADIA_SEL_PEND_HI: rdata_o <= req_q[7:0];
            ADIA_SEL_PEND_LO: rdata_o <= {2'b00, req_q[13:8]};
            ADIA_SEL_VECTOR: rdata_o <= {3'b000, vector};
            ADIA_SEL_MASK_HI: rdata_o <= mask_q[7:0];
            ADIA_SEL_MASK_LO: rdata_o <= {2'b00, mask_q[13:8]};
            ADIA_SEL_STS_HI: rdata_o <= evt_sts_q[7:0];
            ADIA_SEL_STS_LO: rdata_o <= {2'b00, evt_sts_q[13:8]};
            ADIA_SEL_EN_HI: rdata_o <= evt_en_q[7:0];
            ADIA_SEL_EN_LO: rdata_o <= {2'b00, evt_en_q[13:8]};
            default: rdata_o <= '0;
         endcase
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_q);

   a_flags_hi_mirror:
      assert property ((rd_sel == ADIA_SEL_PEND_HI) && $past(rst_n_q)
                       |=> rdata_o == $past(src_d[7:0], 2))
      else $error("upper pending flags do not mirror the requests");

   a_flags_lo_top:
      assert property ((rd_sel == ADIA_SEL_PEND_LO) |=> rdata_o[7:6] == 2'b00)
      else $error("lower pending flags top bits not zero");

   a_vector_upper_zero:
      assert property ((rd_sel == ADIA_SEL_VECTOR) |=> rdata_o[7:5] == 3'b000)
      else $error("vector upper bits not zero");

   a_vector_idle_zero:
      assert property ((rd_sel == ADIA_SEL_VECTOR) && (active == '0) |=> rdata_o == 8'h00)
      else $error("vector not zero with nothing pending");

   a_undervolt_wins:
      assert property ((rd_sel == ADIA_SEL_VECTOR) && active[0] |=> rdata_o == 8'h01)
      else $error("undervoltage does not take the top priority");

   a_trim_lowest:
      assert property ((rd_sel == ADIA_SEL_VECTOR) && (active == 14'h2000)
                       |=> rdata_o == 8'h0e)
      else $error("lone trim request gives the wrong code");

   a_mask_hi_write:
      assert property ((wr_sel == ADIA_SEL_MASK_HI) |=> mask_q[7:0] == $past(wdata_i))
      else $error("upper mask write not taken");

   a_mask_blocks_req:
      assert property ((mask_q == 14'h3fff) |=> !irq_req_o)
      else $error("combined request raised with every source masked");

   a_ro_write_ignored:
      assert property ((wr_sel == ADIA_SEL_VECTOR) || (wr_sel == ADIA_SEL_PEND_HI)
                       |=> $stable(mask_q) && $stable(evt_en_q))
      else $error("write to a read-only register changed state");

   a_sticky_set_wins:
      assert property ((|(rise & evt_clr)) |=> |evt_sts_q)
      else $error("event lost while its bit was being cleared");

endmodule : adia_aggregator

// File: test/adia_src_model.sv
// request line model of the peripheral sources
`timescale 1ns/100ps

module adia_src_model (
   // clock
   input wire logic clk_i,
   // bench control, already qualified by per-source enables
   input wire logic [13:0] level_i,
   input wire logic crank_wake_i,
   // request lines
   output logic [13:0] req_o
);
   // levels come from flag flops, never combinationally
   always_ff @(posedge clk_i) begin
      req_o <= {level_i[13:1], level_i[0] | crank_wake_i};
   end
endmodule : adia_src_model

// File: test/adia_aggregator_tb.sv
// self-checking bench of the analog die interrupt aggregator
`timescale 1ns/100ps
`include "adia_consts.svh"

module adia_aggregator_tb;
   import adia_pkg::*;
   localparam logic [15:0] BB = `ADIA_BASE_BLOCKING;
   localparam logic [15:0] BP = `ADIA_BASE_POSTED;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [15:0] addr_i = 16'h0000;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic [13:0] level = 14'h0000;
   logic crank = 1'b0;
   logic [13:0] req;
   logic irq_req_o;
   logic irq_o;
   logic [7:0] d;
   logic [13:0] e;
   logic [13:0] mk;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;

   adia_src_model SRC (.clk_i(clk_i), .level_i(level), .crank_wake_i(crank), .req_o(req));

   adia_aggregator DUT (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .undervoltage_pending_i(req[0]), .die_hot_pending_i(req[1]),
      .lin_driver_overheat_pending_i(req[2]), .timer_chan0_pending_i(req[3]),
      .timer_chan1_pending_i(req[4]), .timer_chan2_pending_i(req[5]),
      .timer_chan3_pending_i(req[6]), .timer_wrap_pending_i(req[7]),
      .sci_fault_pending_i(req[8]), .sci_transmit_pending_i(req[9]),
      .sci_receive_pending_i(req[10]), .measure_done_pending_i(req[11]),
      .lifetime_wrap_pending_i(req[12]), .trim_request_pending_i(req[13]),
      .irq_req_o(irq_req_o), .irq_o(irq_o)
   );

   initial begin
      forever #25 clk_i = ~clk_i;
   end

   // ****************************************
   // access tasks
   // ****************************************
   task automatic end_sim();
      if (err_total == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr

   // data stand only in the cycle after the strobe edge
   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      v = rdata_o;
   endtask : rd

   task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
      n_compared++;
      if (g !== x) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, x, g);
      end
   endtask : chk

   task automatic rdchk(input string n, input logic [15:0] a, input logic [7:0] x);
      rd(a, d);
      chk(n, x, d);
   endtask : rdchk

   // wait covers model, request flop, status and irq flops
   task automatic src(input logic [13:0] v);
      @(posedge clk_i);
      level <= v;
      repeat (4) @(posedge clk_i);
      #1;
   endtask : src

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         end_sim();
      end
   end

   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rdchk("mask_hi", BB + `ADIA_OFF_MASK_HI, 8'hff);
      rdchk("mask_lo", BB + `ADIA_OFF_MASK_LO, 8'h3f);
      rdchk("vector", BB + `ADIA_OFF_VECTOR, 8'h00);
      rdchk("reserved", BB + `ADIA_OFF_RSVD, 8'h00);
      rdchk("unmapped", BB + 16'h0040, 8'h00);
      // first pass all masked, second pass all enabled
      for (int m = 0; m < 2; m++) begin
         for (int i = 0; i < 14; i++) begin
            e = 14'h0001 << i;
            src(e);
            rdchk("pend_hi", BB + `ADIA_OFF_PEND_HI, e[7:0]);
            rdchk("pend_lo", BB + `ADIA_OFF_PEND_LO, {2'b00, e[13:8]});
            rdchk("vector", BB + `ADIA_OFF_VECTOR, (m == 0) ? 8'h00 : 8'(i + 1));
            chk("irq_req", {7'h00, m == 1}, {7'h00, irq_req_o});
         end
         wr(BB + `ADIA_OFF_MASK_HI, 8'h00);
         wr(BP + `ADIA_OFF_MASK_LO, 8'h00);
      end
      @(posedge clk_i);
      crank <= 1'b1;
      src(14'h0000);
      rdchk("pend_hi", BB + `ADIA_OFF_PEND_HI, 8'h01);
      rdchk("vector", BB + `ADIA_OFF_VECTOR, 8'h01);
      @(posedge clk_i);
      crank <= 1'b0;
      // mask the k highest-priority sources in turn
      src(14'h3fff);
      for (int k = 0; k <= 14; k++) begin
         mk = (14'h3fff << k) ^ 14'h3fff;
         wr(BB + `ADIA_OFF_MASK_HI, mk[7:0]);
         wr(BB + `ADIA_OFF_MASK_LO, {2'b00, mk[13:8]});
         rdchk("vector", BB + `ADIA_OFF_VECTOR, (k == 14) ? 8'h00 : 8'(k + 1));
         chk("irq_req", {7'h00, k != 14}, {7'h00, irq_req_o});
      end
      wr(BP + `ADIA_OFF_MASK_HI, 8'h00);
      wr(BB + `ADIA_OFF_PEND_HI, 8'h00);
      wr(BB + `ADIA_OFF_VECTOR, 8'h1f);
      rdchk("pend_hi", BP + `ADIA_OFF_PEND_HI, 8'hff);
      rdchk("vector", BP + `ADIA_OFF_VECTOR, 8'h01);
      rdchk("mask_hi", BB + `ADIA_OFF_MASK_HI, 8'h00);
      // event status, enable and clear; earlier passes left status bits behind
      src(14'h0000);
      wr(BB + `ADIA_OFF_EVT_CLR_HI, 8'hff);
      wr(BB + `ADIA_OFF_EVT_CLR_LO, 8'h3f);
      rdchk("evt_sts_lo", BB + `ADIA_OFF_EVT_STS_LO, 8'h00);
      wr(BB + `ADIA_OFF_EVT_EN_HI, 8'h02);
      src(14'h0002);
      chk("irq", 8'h01, {7'h00, irq_o});
      wr(BB + `ADIA_OFF_EVT_EN_HI, 8'h00);
      rdchk("evt_sts_hi", BB + `ADIA_OFF_EVT_STS_HI, 8'h02);
      chk("irq", 8'h00, {7'h00, irq_o});
      wr(BB + `ADIA_OFF_EVT_EN_HI, 8'h02);
      wr(BB + `ADIA_OFF_EVT_CLR_HI, 8'h02);
      rdchk("evt_sts_hi", BB + `ADIA_OFF_EVT_STS_HI, 8'h00);
      chk("irq", 8'h00, {7'h00, irq_o});
      wr(BB + `ADIA_OFF_EVT_EN_LO, 8'h20);
      src(14'h2002);
      rdchk("evt_sts_lo", BB + `ADIA_OFF_EVT_STS_LO, 8'h00);
      chk("irq", 8'h00, {7'h00, irq_o});
      // clear strobe lands in the very cycle the new edge is seen: the set must win
      @(posedge clk_i);
      level <= 14'h0004;
      @(posedge clk_i);
      wr(BB + `ADIA_OFF_EVT_CLR_HI, 8'h04);
      rdchk("evt_sts_hi", BB + `ADIA_OFF_EVT_STS_HI, 8'h04);
      end_sim();
   end
endmodule : adia_aggregator_tb
